// [logic/int_exec_map.svh]
/*
  Constants of the integer execute block: fields, opcodes, offsets,
  bit positions and reset values.
  Assumes instruction bit 0 of the big-endian numbering is word bit 31.
*/
`ifndef INT_EXEC_MAP_SVH
`define INT_EXEC_MAP_SVH

// Instruction field positions, little-endian word bit numbers.
`define IEX_PRIM_HI 31
`define IEX_PRIM_LO 26
`define IEX_F1_HI 25
`define IEX_F1_LO 21
`define IEX_F2_HI 20
`define IEX_F2_LO 16
`define IEX_F3_HI 15
`define IEX_F3_LO 11
`define IEX_OE_BIT 10
`define IEX_XO9_HI 9
`define IEX_XO9_LO 1
`define IEX_XO10_HI 10
`define IEX_XO10_LO 1
`define IEX_RC_BIT 0
`define IEX_IMM_HI 15
`define IEX_IMM_LO 0
`define IEX_SIGN_BIT 15

// Primary opcodes.
`define IEX_OPC_XFORM 6'h1F
`define IEX_OPC_ADDI 6'h0E
`define IEX_OPC_ADDIC 6'h0C
`define IEX_OPC_ADDIC_REC 6'h0D
`define IEX_OPC_ADDIS 6'h0F

// Extended opcodes.
`define IEX_XO_ADD 9'h10A
`define IEX_XO_ADDC 9'h00A
`define IEX_XO_ADDE 9'h08A
`define IEX_XO_ADDME 9'h0EA
`define IEX_XO_ADDZE 9'h0CA
`define IEX_XO_AND_DFLT 10'h01C
`define IEX_XO_ANDC 10'h03C

// Register byte offsets on the APB.
`define IEX_ADDR_XER 12'h000
`define IEX_ADDR_CR0 12'h004
`define IEX_ADDR_IRQ_STAT 12'h008
`define IEX_ADDR_IRQ_CLR 12'h00C
`define IEX_ADDR_IRQ_EN 12'h010

// Fixed-point exception register bits.
`define IEX_XER_CA 0
`define IEX_XER_OV 1
`define IEX_XER_SO 2
// Condition field zero bits.
`define IEX_CR_SO 0
`define IEX_CR_EQ 1
`define IEX_CR_GT 2
`define IEX_CR_LT 3
// Interrupt bits.
`define IEX_IRQ_ILLEGAL 0
`define IEX_IRQ_OVERFLOW 1

// Reset values and fill constants.
`define IEX_XER_RST 3'h0
`define IEX_CR0_RST 4'h0
`define IEX_IRQ_RST 2'h0
`define IEX_ZERO32 32'h0000_0000
`define IEX_ONES32 32'hFFFF_FFFF
`define IEX_ZERO16 16'h0000
`define IEX_ONES16 16'hFFFF
`define IEX_ZERO5 5'h00

`endif

// [logic/int_exec_pkg.sv]
/*
  Types shared by the integer execute block and its arithmetic unit.
  Assumes the constant map is included by files that need numbers.
*/
package int_exec_pkg;

  // Operation performed by the arithmetic unit.
  typedef enum logic [1:0] {
    ALU_ADD,
    ALU_AND,
    ALU_ANDC
  } alu_op_e;

  // Complete registered state of the execute block.
  typedef struct packed {
    logic [2:0]  fixed_point_exception_reg;
    logic [3:0]  cr0;
    logic [1:0]  irqStatus;
    logic [1:0]  irqEnable;
    logic        wbValid;
    logic [4:0]  wbAddr;
    logic [31:0] wbData;
    logic        illegal;
    logic [31:0] prdata;
    logic        pslverr;
  } exec_state_s;

endpackage

// [logic/alu_if.sv]
/*
  Carrier between the execute block and its arithmetic unit.
  Assumes the unit answers combinationally in the same cycle.
*/
`timescale 1ns/1ps
interface alu_if;
  logic [31:0]            opA;       // First operand.
  logic [31:0]            opB;       // Second operand.
  logic                   carryIn;   // Carry into bit 0.
  int_exec_pkg::alu_op_e  op;        // Selected operation.
  logic [31:0]            result;    // Operation result.
  logic                   carryOut;  // Unsigned carry out of bit 31.
  logic                   overflow;  // Signed overflow of the sum.

  modport user (output opA, output opB, output carryIn, output op,
                input result, input carryOut, input overflow);
  modport unit (input opA, input opB, input carryIn, input op,
                output result, output carryOut, output overflow);
endinterface

// [logic/int_alu.sv]
/*
  Combinational 32-bit adder and bitwise AND unit.
  Assumes operands are stable for the cycle; it holds no state.
*/
`timescale 1ns/1ps
module int_alu (
  alu_if.unit  bus  // Operands in, result and flags out.
);

  logic [32:0] sum;

  // One 33-bit sum serves every add form; the top bit is the carry.
  always_comb begin
    sum = {1'b0, bus.opA} + {1'b0, bus.opB} + {32'h0000_0000, bus.carryIn};
    bus.carryOut = sum[32];
    bus.overflow = (bus.opA[31] == bus.opB[31]) && (sum[31] != bus.opA[31]);
    unique case (bus.op)
      int_exec_pkg::ALU_ADD:  bus.result = sum[31:0];
      int_exec_pkg::ALU_AND:  bus.result = bus.opA & bus.opB;
      int_exec_pkg::ALU_ANDC: bus.result = bus.opA & ~bus.opB;
      default: bus.result = sum[31:0];
    endcase
  end

endmodule

// [logic/int_exec_top.sv]
/*
  Execute stage for the add family and AND forms, with carry, overflow,
  condition field state and an APB register slave.
  Assumes source data arrive in the cycle of the read addresses, and one
  instruction a cycle from the decoder.
*/
`timescale 1ns/1ps
`include "int_exec_map.svh"

// Notes on behaviour
// RULE1 - The X-form add with code 266 writes the sum of two sources.
// RULE2 - Code 10 writes the sum and sets carry from unsigned overflow.
// RULE3 - Code 138 adds both sources and carry, and updates carry.
// RULE4 - Opcode 14 adds the sign-extended immediate to source or zero.
// RULE5 - Opcode 12 adds the immediate, sets carry, leaves the field.
// RULE6 - Opcode 13 acts like opcode 12 and always updates field zero.
// RULE7 - Opcode 15 adds the immediate shifted to the upper half.
// RULE8 - Code 234 writes source plus carry minus one and updates carry.
// RULE9 - Code 202 writes source plus carry and updates carry.
// RULE10 - AND writes the AND of two sources to the second field.
// RULE11 - Code 60 writes first source AND NOT second source.
// RULE12 - A set record bit updates condition field zero, else it holds.
// RULE13 - A set overflow-enable bit updates overflow and summary flags.
// RULE14 - A register field naming an absent register raises illegal.
// RULE15 - Overflow marks signed overflow; summary overflow is sticky.
// RULE16 - The field shows a signed compare with zero plus summary bit.
module int_exec_top #(
  parameter int          GPR_COUNT = 32,                // Registers built.
  parameter logic [9:0]  AND_XO    = `IEX_XO_AND_DFLT   // AND code.
) (
  input  wire logic        clk,         // Core clock.
  input  wire logic        srst,        // Synchronous reset, active high.
  input  wire logic [11:0] paddr,       // APB address.
  input  wire logic        psel,        // APB select.
  input  wire logic        penable,     // APB enable.
  input  wire logic        pwrite,      // APB direction.
  input  wire logic [31:0] pwdata,      // APB write data.
  output logic      [31:0] prdata,      // APB read data.
  output logic             pready,      // APB ready.
  output logic             pslverr,     // APB error.
  input  wire logic        instValid,   // Instruction present.
  input  wire logic [31:0] instWord,    // Instruction word.
  input  wire logic [31:0] srcAData,    // Data at readAddrA.
  input  wire logic [31:0] srcBData,    // Data at readAddrB.
  output logic      [4:0]  readAddrA,   // First read address.
  output logic      [4:0]  readAddrB,   // Second read address.
  output logic             wbValid,     // Write-back pulse.
  output logic      [4:0]  wbAddr,      // Write-back register.
  output logic      [31:0] wbData,      // Write-back value.
  output logic             illegalInst, // Illegal instruction pulse.
  output logic             irq          // Level interrupt.
);

  if (GPR_COUNT < 1 || GPR_COUNT > 32) begin : g_check
    $error("GPR_COUNT must lie between 1 and 32");
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True when the core has the named register.
  function automatic logic gprExists(input logic [4:0] idx);
    return int'(idx) < GPR_COUNT;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations.

  int_exec_pkg::exec_state_s st_reg;
  int_exec_pkg::exec_state_s st_next;
  alu_if                     aluBus ();

  logic [5:0]  prim;
  logic [8:0]  xo9;
  logic [9:0]  xo10;
  logic [4:0]  fld1;
  logic [4:0]  fld2;
  logic [4:0]  fld3;
  logic [15:0] imm;
  logic [31:0] immExt;
  logic        oeBit;
  logic        rcBit;
  logic        hit;
  logic        isLogic;
  logic        useB;
  logic        record;
  logic        ovEnable;
  logic        writesCarry;
  logic        regsOk;
  logic        exec;
  logic        ovNew;
  logic        soNew;
  logic        apbSetup;
  logic        apbWrite;
  logic        mapped;
  logic [31:0] rdMux;

  ////////////////////////////////////////////////////////////////////////
  // Field extraction.

  // Fields are sliced once for every decode path.
  assign prim   = instWord[`IEX_PRIM_HI:`IEX_PRIM_LO];
  assign xo9    = instWord[`IEX_XO9_HI:`IEX_XO9_LO];
  assign xo10   = instWord[`IEX_XO10_HI:`IEX_XO10_LO];
  assign fld1   = instWord[`IEX_F1_HI:`IEX_F1_LO];
  assign fld2   = instWord[`IEX_F2_HI:`IEX_F2_LO];
  assign fld3   = instWord[`IEX_F3_HI:`IEX_F3_LO];
  assign imm    = instWord[`IEX_IMM_HI:`IEX_IMM_LO];
  assign oeBit  = instWord[`IEX_OE_BIT];
  assign rcBit  = instWord[`IEX_RC_BIT];
  assign immExt = {imm[`IEX_SIGN_BIT] ? `IEX_ONES16 : `IEX_ZERO16, imm};

  // The logic forms read their first source from the first field.
  assign readAddrA = isLogic ? fld1 : fld2;
  assign readAddrB = fld3;

  ////////////////////////////////////////////////////////////////////////
  // Decode and operand selection.

  // Unknown opcodes are left for other units.
  always_comb begin
    hit            = 1'b0;
    isLogic        = 1'b0;
    useB           = 1'b0;
    record         = 1'b0;
    ovEnable       = 1'b0;
    writesCarry    = 1'b0;
    aluBus.opA     = srcAData;
    aluBus.opB     = srcBData;
    aluBus.carryIn = 1'b0;
    aluBus.op      = int_exec_pkg::ALU_ADD;
    unique case (prim)
      `IEX_OPC_XFORM: begin
        record   = rcBit; // [RULE12]
        ovEnable = oeBit; // [RULE13]
        useB     = 1'b1;
        if (xo10 == AND_XO) begin
          hit       = 1'b1;
          isLogic   = 1'b1;
          ovEnable  = 1'b0;
          aluBus.op = int_exec_pkg::ALU_AND; // [RULE10]
        end else if (xo10 == `IEX_XO_ANDC) begin
          hit       = 1'b1;
          isLogic   = 1'b1;
          ovEnable  = 1'b0;
          aluBus.op = int_exec_pkg::ALU_ANDC; // [RULE11]
        end else begin
          unique case (xo9)
            `IEX_XO_ADD: begin
              hit = 1'b1; // [RULE1]
            end
            `IEX_XO_ADDC: begin
              hit         = 1'b1;
              writesCarry = 1'b1; // [RULE2]
            end
            `IEX_XO_ADDE: begin
              hit            = 1'b1;
              writesCarry    = 1'b1;
              aluBus.carryIn = st_reg.fixed_point_exception_reg[`IEX_XER_CA]; // [RULE3]
            end
            `IEX_XO_ADDME: begin
              hit            = 1'b1;
              useB           = 1'b0;
              writesCarry    = 1'b1;
              aluBus.opB     = `IEX_ONES32; // [RULE8]
              aluBus.carryIn = st_reg.fixed_point_exception_reg[`IEX_XER_CA];
            end
            `IEX_XO_ADDZE: begin
              hit            = 1'b1;
              useB           = 1'b0;
              writesCarry    = 1'b1;
              aluBus.opB     = `IEX_ZERO32; // [RULE9]
              aluBus.carryIn = st_reg.fixed_point_exception_reg[`IEX_XER_CA];
            end
            default: begin
              hit = 1'b0;
            end
          endcase
        end
      end
      `IEX_OPC_ADDI: begin
        hit        = 1'b1;
        aluBus.opA = (fld2 == `IEX_ZERO5) ? `IEX_ZERO32 : srcAData; // [RULE4]
        aluBus.opB = immExt;
      end
      `IEX_OPC_ADDIC: begin
        hit         = 1'b1;
        writesCarry = 1'b1; // [RULE5]
        aluBus.opB  = immExt;
      end
      `IEX_OPC_ADDIC_REC: begin
        hit         = 1'b1;
        writesCarry = 1'b1;
        record      = 1'b1; // [RULE6]
        aluBus.opB  = immExt;
      end
      `IEX_OPC_ADDIS: begin
        hit        = 1'b1;
        aluBus.opA = (fld2 == `IEX_ZERO5) ? `IEX_ZERO32 : srcAData; // [RULE7]
        aluBus.opB = {imm, `IEX_ZERO16};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  int_alu u_alu (
    .bus (aluBus.unit)
  );

  // Every named field must exist; the third only where it is read.
  assign regsOk = gprExists(fld1) && gprExists(fld2)
                  && (!useB || gprExists(fld3)); // [RULE14]
  assign exec   = instValid && hit && regsOk;

  // Summary overflow only ever gains bits from execution.
  assign ovNew = aluBus.overflow; // [RULE15]
  assign soNew = st_reg.fixed_point_exception_reg[`IEX_XER_SO] | (ovEnable & ovNew);

  ////////////////////////////////////////////////////////////////////////
  // APB decode.

  // Reads are captured in the setup cycle: no wait states, and
  // prdata still comes from a flip-flop.
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite;
  assign mapped   = (paddr == `IEX_ADDR_XER) || (paddr == `IEX_ADDR_CR0)
                    || (paddr == `IEX_ADDR_IRQ_STAT)
                    || (paddr == `IEX_ADDR_IRQ_CLR)
                    || (paddr == `IEX_ADDR_IRQ_EN);

  // Read multiplexer; the clear register reads as zero.
  always_comb begin
    rdMux = `IEX_ZERO32;
    if (paddr == `IEX_ADDR_XER) begin
      rdMux = {29'h0000_0000, st_reg.fixed_point_exception_reg};
    end else if (paddr == `IEX_ADDR_CR0) begin
      rdMux = {28'h000_0000, st_reg.cr0};
    end else if (paddr == `IEX_ADDR_IRQ_STAT) begin
      rdMux = {30'h0000_0000, st_reg.irqStatus};
    end else if (paddr == `IEX_ADDR_IRQ_EN) begin
      rdMux = {30'h0000_0000, st_reg.irqEnable};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  // Software writes land first so same-cycle execution overrides
  // them; an event never loses to a clear.
  always_comb begin
    st_next         = st_reg;
    st_next.wbValid = 1'b0;
    st_next.illegal = 1'b0;
    if (apbSetup) begin
      st_next.prdata  = rdMux;
      st_next.pslverr = !mapped;
    end
    if (apbWrite && paddr == `IEX_ADDR_XER) begin
      st_next.fixed_point_exception_reg = pwdata[`IEX_XER_SO:`IEX_XER_CA];  // Only path clearing SO.
    end
    if (apbWrite && paddr == `IEX_ADDR_IRQ_EN) begin
      st_next.irqEnable = pwdata[`IEX_IRQ_OVERFLOW:`IEX_IRQ_ILLEGAL];
    end
    if (apbWrite && paddr == `IEX_ADDR_IRQ_CLR) begin
      st_next.irqStatus = st_reg.irqStatus
                          & ~pwdata[`IEX_IRQ_OVERFLOW:`IEX_IRQ_ILLEGAL];
    end
    if (instValid && hit && !regsOk) begin
      st_next.illegal = 1'b1; // [RULE14]
      st_next.irqStatus[`IEX_IRQ_ILLEGAL] = 1'b1;
    end
    if (exec) begin
      st_next.wbValid = 1'b1;
      st_next.wbAddr  = isLogic ? fld2 : fld1; // [RULE10]
      st_next.wbData  = aluBus.result; // [RULE1]
      if (writesCarry) begin
        st_next.fixed_point_exception_reg[`IEX_XER_CA] = aluBus.carryOut; // [RULE2]
      end
      if (ovEnable) begin
        st_next.fixed_point_exception_reg[`IEX_XER_OV] = ovNew; // [RULE13]
        st_next.fixed_point_exception_reg[`IEX_XER_SO] = soNew; // [RULE15]
        if (ovNew) begin
          st_next.irqStatus[`IEX_IRQ_OVERFLOW] = 1'b1;
        end
      end
      if (record) begin
        st_next.cr0[`IEX_CR_LT] = aluBus.result[31]; // [RULE16]
        st_next.cr0[`IEX_CR_GT] = !aluBus.result[31]
                                  && (aluBus.result != `IEX_ZERO32);
        st_next.cr0[`IEX_CR_EQ] = aluBus.result == `IEX_ZERO32;
        st_next.cr0[`IEX_CR_SO] = soNew; // [RULE12]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset clears flags, pulses and the interrupt enables.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg           <= '0;
      st_reg.fixed_point_exception_reg       <= `IEX_XER_RST;
      st_reg.cr0       <= `IEX_CR0_RST;
      st_reg.irqStatus <= `IEX_IRQ_RST;
      st_reg.irqEnable <= `IEX_IRQ_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Zero-wait slave.
  assign pready      = 1'b1;
  assign prdata      = st_reg.prdata;
  assign pslverr     = st_reg.pslverr;
  assign wbValid     = st_reg.wbValid;
  assign wbAddr      = st_reg.wbAddr;
  assign wbData      = st_reg.wbData;
  assign illegalInst = st_reg.illegal;
  assign irq         = |(st_reg.irqStatus & st_reg.irqEnable);

endmodule

// [bench/int_exec_top_assertions.sv]
/*
  Checks on the execute block's write-back results, AND read addresses and illegal pulse.
  Assumes same-cycle register file reads.
*/
`timescale 1ns/1ps
`include "int_exec_map.svh"
module int_exec_checker #(
  parameter int         GPR_COUNT = 32,
  parameter logic [9:0] AND_XO    = `IEX_XO_AND_DFLT
) (
  input wire logic        clk,         // Core clock.
  input wire logic        srst,        // Synchronous reset.
  input wire logic        instValid,   // Instruction present.
  input wire logic [31:0] instWord,    // Instruction word.
  input wire logic [31:0] srcAData,    // First source data.
  input wire logic [31:0] srcBData,    // Second source data.
  input wire logic [4:0]  readAddrA,   // First read address.
  input wire logic [4:0]  readAddrB,   // Second read address.
  input wire logic        wbValid,     // Write-back pulse.
  input wire logic [4:0]  wbAddr,      // Write-back register.
  input wire logic [31:0] wbData,      // Write-back value.
  input wire logic        illegalInst  // Illegal pulse.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [5:0]  prim;
  logic [4:0]  f1, f2, f3;
  logic [9:0]  xo10;
  logic        ok12, isX;
  logic [31:0] sext, base;
  ////////////////////////////////////////////////////////////////////////////
  // Field views shared by the checks.
  assign prim   = instWord[31:26];
  assign f1     = instWord[25:21];
  assign f2     = instWord[20:16];
  assign f3     = instWord[15:11];
  assign xo10   = instWord[10:1];
  assign ok12   = int'(f1) < GPR_COUNT && int'(f2) < GPR_COUNT;
  assign isX    = instValid && prim == `IEX_OPC_XFORM && ok12
                  && int'(f3) < GPR_COUNT;
  assign sext   = {{16{instWord[15]}}, instWord[15:0]};
  assign base   = (f2 == 5'h00) ? 32'h0 : srcAData;
  ////////////////////////////////////////////////////////////////////////////
  AST_ADD_SUM: assert property (isX && xo10 != AND_XO &&
    xo10 != `IEX_XO_ANDC && instWord[9:1] == `IEX_XO_ADD |=> wbValid &&
    wbData == $past(srcAData + srcBData) && wbAddr == $past(f1))
    else $error("add result wrong");
  AST_ADDI: assert property (instValid && ok12 &&
    prim == `IEX_OPC_ADDI |=> wbValid && wbData == $past(base + sext))
    else $error("add immediate result wrong");
  AST_ADDIC: assert property (instValid && ok12 &&
    prim == `IEX_OPC_ADDIC |=> wbValid && wbData == $past(srcAData + sext))
    else $error("carrying immediate result wrong");
  AST_ADDIS: assert property (instValid && ok12 &&
    prim == `IEX_OPC_ADDIS |=> wbValid &&
    wbData == $past(base + {instWord[15:0], 16'h0}))
    else $error("shifted immediate result wrong");
  AST_AND: assert property (isX && xo10 == AND_XO |=> wbValid &&
    wbData == $past(srcAData & srcBData) && wbAddr == $past(f2))
    else $error("and result wrong");
  AST_ANDC: assert property (isX && xo10 == `IEX_XO_ANDC |=>
    wbValid && wbData == $past(srcAData & ~srcBData) && wbAddr == $past(f2))
    else $error("andc result wrong");
  AST_AND_SRC: assert property (instValid &&
    prim == `IEX_OPC_XFORM && xo10 == AND_XO |->
    readAddrA == f1 && readAddrB == f3)
    else $error("and read addresses wrong");
  AST_ILLEGAL: assert property (instValid && !ok12 &&
    prim == `IEX_OPC_ADDI |=> illegalInst && !wbValid)
    else $error("absent register not refused");
  AST_WB_CAUSE: assert property (wbValid |->
    $past(instValid) && !illegalInst)
    else $error("write-back without instruction");
endmodule

bind int_exec_top int_exec_checker #(
  .GPR_COUNT(GPR_COUNT),
  .AND_XO   (AND_XO)
) chk (
  .clk(clk), .srst(srst), .instValid(instValid), .instWord(instWord),
  .srcAData(srcAData), .srcBData(srcBData), .readAddrA(readAddrA),
  .readAddrB(readAddrB), .wbValid(wbValid), .wbAddr(wbAddr),
  .wbData(wbData), .illegalInst(illegalInst)
);

// [bench/gpr_file_model.sv]
/*
  Behavioural register file facing the execute block.
  Assumes the bench preloads entries by hierarchical assignment.
*/
`timescale 1ns/1ps
module gpr_file_model (
  input  wire logic        clk,        // Core clock.
  input  wire logic [4:0]  readAddrA,  // First read address.
  input  wire logic [4:0]  readAddrB,  // Second read address.
  input  wire logic        wbValid,    // Write-back strobe.
  input  wire logic [4:0]  wbAddr,     // Write-back register.
  input  wire logic [31:0] wbData,     // Write-back value.
  output logic      [31:0] srcAData,   // Data at first address.
  output logic      [31:0] srcBData    // Data at second address.
);
  logic [31:0] mem [32];
  // Reads are combinational; an entry never loaded reads unknown.
  assign srcAData = mem[readAddrA];
  assign srcBData = mem[readAddrB];
  // Write-back lands at the edge that closes the pulse.
  always @(posedge clk) begin
    if (wbValid === 1'b1) begin
      mem[wbAddr] <= wbData;
    end
  end
endmodule

// [bench/tb_integer_add_and_logic_exec.sv]
/*
  Bench for the integer execute block.
  Assumes the register file model and a zero-wait APB slave.
*/
`timescale 1ns/1ps
`include "int_exec_map.svh"
module tb_integer_add_and_logic_exec;
  typedef struct {
    logic [5:0]  prim;
    logic [4:0]  ra;
    logic [15:0] low;
    logic [31:0] a, b;
    logic [2:0]  xi;
    logic [31:0] res;
    logic [4:0]  wa;
    logic [2:0]  fixed_point_exception_reg;
    logic [3:0]  cr;
  } row_s;
  row_s        rows [15];
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq;
  logic        instValid, wbValid, illegalInst, seenWb, seenIll, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, instWord, srcAData, srcBData, wbData, rd;
  logic [4:0]  readAddrA, readAddrB, wbAddr;
  int          n_mismatch, tests_run, cycles;
  ////////////////////////////////////////////////////////////////////////////
  // Sixteen registers, so high fields are refused.
  int_exec_top #(.GPR_COUNT(16)) dut (
    .clk(clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instValid(instValid), .instWord(instWord),
    .srcAData(srcAData), .srcBData(srcBData), .readAddrA(readAddrA),
    .readAddrB(readAddrB), .wbValid(wbValid), .wbAddr(wbAddr),
    .wbData(wbData), .illegalInst(illegalInst), .irq(irq));
  gpr_file_model rf (
    .clk(clk), .readAddrA(readAddrA), .readAddrB(readAddrB),
    .wbValid(wbValid), .wbAddr(wbAddr), .wbData(wbData),
    .srcAData(srcAData), .srcBData(srcBData));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, then an idle edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Registered outputs are sampled just after the edge.
  task automatic issue(input logic [31:0] w);
    instValid <= 1'b1;
    instWord  <= w;
    @(posedge clk);
    instValid <= 1'b0;
    #1;
    seenWb  = wbValid;
    seenIll = illegalInst;
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A hang ends in the normal report.
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 3000) begin
      n_mismatch++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; instValid = 1'b0; instWord = 32'h0;
    rows = '{
      '{6'd31, 5'd4, {5'd5, 1'b0, 9'd266, 1'b0}, 32'h7FFF_FFFF, 32'h1, 3'h0,
        32'h8000_0000, 5'd3, 3'h0, 4'h0},
      '{6'd31, 5'd4, {5'd5, 1'b1, 9'd266, 1'b1}, 32'h7FFF_FFFF, 32'h1, 3'h0,
        32'h8000_0000, 5'd3, 3'h6, 4'h9},
      '{6'd31, 5'd4, {5'd5, 1'b1, 9'd266, 1'b0}, 32'h1, 32'h1, 3'h4,
        32'h2, 5'd3, 3'h4, 4'h9},
      '{6'd31, 5'd4, {5'd5, 1'b0, 9'd10, 1'b0}, 32'hFFFF_FFFF, 32'h2, 3'h0,
        32'h1, 5'd3, 3'h1, 4'h9},
      '{6'd31, 5'd4, {5'd5, 1'b0, 9'd138, 1'b1}, 32'hFFFF_FFFF, 32'h0, 3'h1,
        32'h0, 5'd3, 3'h1, 4'h2},
      '{6'd31, 5'd4, {5'd5, 1'b0, 9'd234, 1'b0}, 32'h5, 32'h0, 3'h1,
        32'h5, 5'd3, 3'h1, 4'h2},
      '{6'd31, 5'd4, {5'd5, 1'b0, 9'd202, 1'b1}, 32'h7FFF_FFFF, 32'h0, 3'h1,
        32'h8000_0000, 5'd3, 3'h0, 4'h8},
      '{6'd14, 5'd4, 16'hFFFE, 32'h10, 32'h0, 3'h1, 32'hE, 5'd3, 3'h1, 4'h8},
      '{6'd14, 5'd0, 16'h8000, 32'h1234_5678, 32'h0, 3'h0, 32'hFFFF_8000,
        5'd3, 3'h0, 4'h8},
      '{6'd12, 5'd4, 16'hFFFF, 32'h1, 32'h0, 3'h0, 32'h0, 5'd3, 3'h1, 4'h8},
      '{6'd13, 5'd4, 16'hFFFB, 32'h5, 32'h0, 3'h4, 32'h0, 5'd3, 3'h5, 4'h3},
      '{6'd15, 5'd4, 16'h8000, 32'h1, 32'h0, 3'h0, 32'h8000_0001, 5'd3, 3'h0,
        4'h3},
      '{6'd15, 5'd0, 16'h1234, 32'h1234_5678, 32'h0, 3'h0, 32'h1234_0000,
        5'd3, 3'h0, 4'h3},
      '{6'd31, 5'd4, {5'd5, 10'd28, 1'b1}, 32'hF0F0_00FF, 32'hFF00_00F0,
        3'h0, 32'hF000_00F0, 5'd4, 3'h0, 4'h8},
      '{6'd31, 5'd4, {5'd5, 10'd60, 1'b0}, 32'hF0F0_00FF, 32'hFF00_00F0,
        3'h0, 32'h00F0_000F, 5'd4, 3'h0, 4'h8}};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // Each row: preset flags and sources, run, compare.
    foreach (rows[i]) begin
      apb(1'b1, `IEX_ADDR_XER, {29'h0, rows[i].xi});
      rf.mem[3] = rows[i].a;
      rf.mem[rows[i].ra] = rows[i].a;
      rf.mem[5] = rows[i].b;
      issue({rows[i].prim, 5'd3, rows[i].ra, rows[i].low});
      chk("wb valid", 32'h1, seenWb);
      chk("wb addr", rows[i].wa, wbAddr);
      chk("wb data", rows[i].res, wbData);
      apb(1'b0, `IEX_ADDR_XER, 32'h0);
      chk("flags", rows[i].fixed_point_exception_reg, rd);
      apb(1'b0, `IEX_ADDR_CR0, 32'h0);
      chk("cond field", rows[i].cr, rd);
    end
    // Back-to-back carry chain.
    apb(1'b1, `IEX_ADDR_XER, 32'h0);
    rf.mem[4] = 32'hFFFF_FFFF;
    rf.mem[5] = 32'h1;
    instValid <= 1'b1;
    instWord  <= {6'd31, 5'd3, 5'd4, 5'd5, 1'b0, 9'd10, 1'b0};
    @(posedge clk);
    instWord  <= {6'd31, 5'd3, 5'd4, 5'd5, 1'b0, 9'd138, 1'b0};
    #1 chk("chain first", 32'h0, wbData);
    @(posedge clk);
    instValid <= 1'b0;
    #1 chk("chain second", 32'h1, wbData);
    @(posedge clk);
    // Absent target or third field is refused.
    issue({6'd14, 5'd20, 5'd4, 16'h1});
    chk("illegal target", 32'h1, seenIll);
    chk("no write-back", 32'h0, seenWb);
    issue({6'd31, 5'd3, 5'd4, 5'd17, 1'b0, 9'd266, 1'b0});
    chk("illegal third", 32'h1, seenIll);
    // Interrupt: masked, raised, cleared bit by bit.
    apb(1'b0, `IEX_ADDR_IRQ_STAT, 32'h0);
    chk("status", 32'h3, rd);
    chk("irq masked", 32'h0, irq);
    apb(1'b1, `IEX_ADDR_IRQ_EN, 32'h1);
    chk("irq on", 32'h1, irq);
    apb(1'b1, `IEX_ADDR_IRQ_CLR, 32'h1);
    apb(1'b0, `IEX_ADDR_IRQ_STAT, 32'h0);
    chk("status cleared", 32'h2, rd);
    chk("irq off", 32'h0, irq);
    apb(1'b1, `IEX_ADDR_IRQ_EN, 32'h3);
    chk("irq overflow", 32'h1, irq);
    apb(1'b1, `IEX_ADDR_IRQ_CLR, 32'h2);
    chk("irq cleared", 32'h0, irq);
    // Read-only field ignores writes; unmapped answers an error.
    apb(1'b1, `IEX_ADDR_CR0, 32'hF);
    apb(1'b0, `IEX_ADDR_CR0, 32'h0);
    chk("cond field kept", 32'h8, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    // Mid-run reset clears every flag.
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `IEX_ADDR_XER, 32'h0);
    chk("flags reset", 32'h0, rd);
    apb(1'b0, `IEX_ADDR_CR0, 32'h0);
    chk("cond reset", 32'h0, rd);
    apb(1'b0, `IEX_ADDR_IRQ_EN, 32'h0);
    chk("enable reset", 32'h0, rd);
    chk("irq reset", 32'h0, irq);
    stop_test();
  end
endmodule
